// >>> strap_config_latch.sv
// Strap capture, eeprom override and flow control configuration
//
// Summary of operation
// - Port2 strap low: auto flow, advertise pause
// - Port2 strap high: manual flow, no pause advert
// - Host backpressure strap sets backpressure default
// - Host flow strap sets both pause defaults
// - Host manual strap sets host manual select
// - Heartbeat strap sets heartbeat off default
// - Hard straps captured only at resets
// - Eeprom loader never alters hard straps
// - Type strap picks three-wire or i2c
// - Two-bit size strap sets eeprom range
// - Address strap shifts management addresses by one
`include "strap_config_defs.svh"
`default_nettype none
module strap_config_latch (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic external_reset_pin_n,
   input wire strap_config_pkg::soft_strap_t soft_straps,
   input wire strap_config_pkg::hard_strap_t hard_straps,
   input wire logic loader_wr_en,
   input wire strap_config_pkg::flow_cfg_t loader_wr_data,
   input wire strap_config_pkg::flow_cfg_t loader_wr_mask,
   input wire logic loader_done,
   input wire logic sw_wr_en,
   input wire strap_config_pkg::flow_cfg_t sw_wr_data,
   input wire strap_config_pkg::flow_cfg_t sw_wr_mask,
   input wire strap_config_pkg::pause_pair_t port2_autoneg_pause,
   input wire strap_config_pkg::pause_pair_t host_virtual_an_pause,
   output strap_config_pkg::flow_cfg_t flow_cfg,
   output strap_config_pkg::hard_cfg_t hard_cfg,
   output strap_config_pkg::pause_pair_t port2_pause_active,
   output strap_config_pkg::pause_pair_t host_pause_active,
   output logic loader_window_open,
   output logic config_ready
);
   import strap_config_pkg::*;

   typedef enum logic [1:0] {
      st_capture,
      st_load,
      st_run
   } phase_t;

   phase_t phase_reg;
   phase_t phase_next;
   logic capture;
   flow_cfg_t cfg_reg;
   flow_cfg_t cfg_next;
   pause_pair_t port2_pause_reg;
   pause_pair_t host_pause_reg;

   // Merge of masked writes, shared by the loader and software paths
   function automatic flow_cfg_t merge_masked(input flow_cfg_t old_v,
                                              input flow_cfg_t new_v,
                                              input flow_cfg_t mask);
      merge_masked = (old_v & ~mask) | (new_v & mask);
   endfunction

   // Defaults that a given soft strap set produces
   function automatic flow_cfg_t strap_defaults(input soft_strap_t s);
      strap_defaults.port2_manual_flow_select = s.port2_manual_flow_strap;
      strap_defaults.port2_tx_pause_enable = s.port2_fullduplex_flow_strap;
      strap_defaults.port2_rx_pause_enable = s.port2_fullduplex_flow_strap;
      // Pause advertised only when auto flow control is in use
      strap_defaults.port2_advert_pause =
         ~s.port2_manual_flow_strap;
      strap_defaults.host_backpressure_enable =
         s.host_backpressure_strap;
      strap_defaults.host_tx_pause_enable =
         s.host_fullduplex_flow_strap;
      strap_defaults.host_rx_pause_enable =
         s.host_fullduplex_flow_strap;
      strap_defaults.host_manual_flow_select =
         s.host_manual_flow_strap;
      strap_defaults.heartbeat_off_bit =
         s.heartbeat_disable_strap;
   endfunction

   // Manual select takes the enable bits, else the resolved pair
   function automatic pause_pair_t pause_pick(input logic manual,
                                              input logic tx_en,
                                              input logic rx_en,
                                              input pause_pair_t resolved);
      if (manual) begin
         pause_pick.tx = tx_en;
         pause_pick.rx = rx_en;
      end else begin
         pause_pick = resolved;
      end
   endfunction

   // Capture while in the capture phase: first edge after rst release,
   // and every edge that follows one where the external reset pin was seen asserted
   assign capture = (phase_reg == st_capture);

   always_comb begin
      phase_next = phase_reg;
      case (phase_reg)
         st_capture: begin
            if (external_reset_pin_n) begin
               phase_next = st_load;
            end
         end
         st_load: begin
            if (loader_done) begin
               phase_next = st_run;
            end
         end
         st_run: begin
            phase_next = st_run;
         end
         default: begin
            phase_next = st_capture;
         end
      endcase
      if (!external_reset_pin_n) begin
         phase_next = st_capture;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         phase_reg <= st_capture;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // Configuration register: strap default, then loader, then software
   always_comb begin
      cfg_next = cfg_reg;
      case (phase_reg)
         st_capture: begin
            cfg_next = strap_defaults(soft_straps);
         end
         st_load: begin
            if (loader_wr_en) begin
               cfg_next = merge_masked(cfg_reg, loader_wr_data,
                                       loader_wr_mask);
            end
         end
         st_run: begin
            if (sw_wr_en) begin
               cfg_next = merge_masked(cfg_reg, sw_wr_data, sw_wr_mask);
            end
         end
         default: begin
            cfg_next = cfg_reg;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_reg.port2_manual_flow_select <= `PORT2_MANUAL_RST;
         cfg_reg.port2_tx_pause_enable <= `PORT2_FD_FLOW_RST;
         cfg_reg.port2_rx_pause_enable <= `PORT2_FD_FLOW_RST;
         cfg_reg.port2_advert_pause <= ~`PORT2_MANUAL_RST;
         cfg_reg.host_backpressure_enable <= `HOST_BP_RST;
         cfg_reg.host_tx_pause_enable <= `HOST_FD_FLOW_RST;
         cfg_reg.host_rx_pause_enable <= `HOST_FD_FLOW_RST;
         cfg_reg.host_manual_flow_select <= `HOST_MANUAL_RST;
         cfg_reg.heartbeat_off_bit <= `HEARTBEAT_OFF_RST;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   // Effective pause per port; held off until configuration settles
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         port2_pause_reg <= '0;
      end else if (phase_reg != st_run) begin
         port2_pause_reg <= '0;
      end else begin
         port2_pause_reg <= pause_pick(cfg_reg.port2_manual_flow_select,
            cfg_reg.port2_tx_pause_enable, cfg_reg.port2_rx_pause_enable,
            port2_autoneg_pause);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         host_pause_reg <= '0;
      end else if (phase_reg != st_run) begin
         host_pause_reg <= '0;
      end else begin
         host_pause_reg <= pause_pick(cfg_reg.host_manual_flow_select,
            cfg_reg.host_tx_pause_enable, cfg_reg.host_rx_pause_enable,
            host_virtual_an_pause);
      end
   end

   // Loader data never feeds this instance
   hard_strap_decode u_hard (
      .core_clk(core_clk),
      .rst(rst),
      .capture(capture),
      .pins(hard_straps),
      .cfg(hard_cfg)
   );

   assign flow_cfg = cfg_reg;
   assign port2_pause_active = port2_pause_reg;
   assign host_pause_active = host_pause_reg;
   assign loader_window_open = (phase_reg == st_load);
   assign config_ready = (phase_reg == st_run);

endmodule
`default_nettype wire

// >>> strap_config_defs.svh
// Strap reset values, field positions and decode constants
`ifndef STRAP_CONFIG_DEFS_SVH
`define STRAP_CONFIG_DEFS_SVH

// Register values held before the first strap capture
`define PORT2_MANUAL_RST 1'b0
`define PORT2_FD_FLOW_RST 1'b1
`define HOST_BP_RST 1'b1
`define HOST_FD_FLOW_RST 1'b1
`define HOST_MANUAL_RST 1'b0
`define HEARTBEAT_OFF_RST 1'b0

// Soft strap vector field positions
`define SOFT_W 6
`define SOFT_P2_MANUAL 5
`define SOFT_P2_FD_FLOW 4
`define SOFT_HOST_BP 3
`define SOFT_HOST_FD_FLOW 2
`define SOFT_HOST_MANUAL 1
`define SOFT_HEARTBEAT 0

// Flow configuration vector width
`define FLOW_W 9

// Eeprom interface selection codes
`define EEPROM_TYPE_THREE_WIRE 1'b0
`define EEPROM_TYPE_I2C 1'b1
`define EEPROM_SIZE_RST 2'h0

// Management address map
`define PHY_ADDR_W 5
`define PHY_ADDR_BASE_SEL0 5'h00
`define PHY_ADDR_BASE_SEL1 5'h01
`define PHY_ADDR_COUNT 3
`define PHY_ADDR_SEL_RST 1'b0

`endif

// >>> strap_config_pkg.sv
// Types shared by the strap latch and its hard strap decoder
`default_nettype none
package strap_config_pkg;

   typedef enum logic {
      eeprom_three_wire,
      eeprom_i2c
   } eeprom_mode_t;

   typedef struct packed {
      logic port2_manual_flow_strap;
      logic port2_fullduplex_flow_strap;
      logic host_backpressure_strap;
      logic host_fullduplex_flow_strap;
      logic host_manual_flow_strap;
      logic heartbeat_disable_strap;
   } soft_strap_t;

   typedef struct packed {
      logic port2_manual_flow_select;
      logic port2_tx_pause_enable;
      logic port2_rx_pause_enable;
      logic port2_advert_pause;
      logic host_backpressure_enable;
      logic host_tx_pause_enable;
      logic host_rx_pause_enable;
      logic host_manual_flow_select;
      logic heartbeat_off_bit;
   } flow_cfg_t;

   typedef struct packed {
      logic eeprom_type_strap;
      logic [1:0] eeprom_size_strap;
      logic phy_addr_sel_strap;
   } hard_strap_t;

   typedef struct packed {
      eeprom_mode_t eeprom_mode;
      logic [1:0] eeprom_size;
      logic [4:0] vphy_addr;
      logic [4:0] port1_phy_addr;
      logic [4:0] port2_phy_addr;
   } hard_cfg_t;

   typedef struct packed {
      logic tx;
      logic rx;
   } pause_pair_t;

endpackage
`default_nettype wire

// >>> hard_strap_decode.sv
// Hard strap latch and decode into direct configuration values
`include "strap_config_defs.svh"
`default_nettype none
module hard_strap_decode (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic capture,
   input wire strap_config_pkg::hard_strap_t pins,
   output strap_config_pkg::hard_cfg_t cfg
);
   import strap_config_pkg::*;

   logic type_reg;
   logic [1:0] size_reg;
   logic [`PHY_ADDR_W-1:0] addr_reg [`PHY_ADDR_COUNT];

   // Pins only sampled on a capture pulse; no eeprom path reaches here
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         type_reg <= `EEPROM_TYPE_THREE_WIRE;
         size_reg <= `EEPROM_SIZE_RST;
      end else if (capture) begin
         type_reg <= pins.eeprom_type_strap;
         size_reg <= pins.eeprom_size_strap;
      end
   end

   // Virtual, port 1 and port 2 addresses follow a common base
   genvar i;
   generate
      for (i = 0; i < `PHY_ADDR_COUNT; i++) begin : g_addr
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               addr_reg[i] <= `PHY_ADDR_BASE_SEL0 + `PHY_ADDR_W'(i);
            end else if (capture) begin
               addr_reg[i] <= (pins.phy_addr_sel_strap ?
                  `PHY_ADDR_BASE_SEL1 : `PHY_ADDR_BASE_SEL0) +
                  `PHY_ADDR_W'(i);
            end
         end
      end
   endgenerate

   always_comb begin
      cfg.eeprom_mode = (type_reg == `EEPROM_TYPE_I2C) ?
         eeprom_i2c : eeprom_three_wire;
      cfg.eeprom_size = size_reg;
      cfg.vphy_addr = addr_reg[0];
      cfg.port1_phy_addr = addr_reg[1];
      cfg.port2_phy_addr = addr_reg[2];
   end

endmodule
`default_nettype wire

// >>> strap_config_latch_monitor.sv
// Port checker for the strap latch
`default_nettype none
module strap_config_latch_monitor (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic external_reset_pin_n,
   input wire strap_config_pkg::soft_strap_t soft_straps,
   input wire strap_config_pkg::hard_strap_t hard_straps,
   input wire logic loader_wr_en,
   input wire strap_config_pkg::flow_cfg_t loader_wr_data,
   input wire strap_config_pkg::flow_cfg_t loader_wr_mask,
   input wire logic loader_done,
   input wire logic sw_wr_en,
   input wire strap_config_pkg::flow_cfg_t sw_wr_data,
   input wire strap_config_pkg::flow_cfg_t sw_wr_mask,
   input wire strap_config_pkg::pause_pair_t port2_autoneg_pause,
   input wire strap_config_pkg::pause_pair_t host_virtual_an_pause,
   input wire strap_config_pkg::flow_cfg_t flow_cfg,
   input wire strap_config_pkg::hard_cfg_t hard_cfg,
   input wire strap_config_pkg::pause_pair_t port2_pause_active,
   input wire strap_config_pkg::pause_pair_t host_pause_active,
   input wire logic loader_window_open,
   input wire logic config_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   import strap_config_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic capture_phase;
   logic [1:0] p2_sel;
   logic [1:0] host_sel;
   assign capture_phase = !loader_window_open && !config_ready;
   // Pause source as the run phase should pick it
   assign p2_sel = flow_cfg.port2_manual_flow_select ?
      {flow_cfg.port2_tx_pause_enable, flow_cfg.port2_rx_pause_enable} :
      port2_autoneg_pause;
   assign host_sel = flow_cfg.host_manual_flow_select ?
      {flow_cfg.host_tx_pause_enable, flow_cfg.host_rx_pause_enable} :
      host_virtual_an_pause;
   function automatic logic [8:0] soft_map(logic [5:0] s);
      return {s[5], s[4], s[4], ~s[5], s[3], s[2], s[2], s[1], s[0]};
   endfunction
   function automatic logic [17:0] hard_map(logic [3:0] h);
      return {h[3], h[2:1], 4'h0, h[0], 5'(h[0]) + 5'h01,
         5'(h[0]) + 5'h02};
   endfunction
   a_soft_capture: assert property (
      capture_phase |=> flow_cfg == soft_map($past(soft_straps)))
      else $error("soft strap capture wrong");
   a_hard_capture: assert property (
      capture_phase |=> hard_cfg == hard_map($past(hard_straps)))
      else $error("hard strap capture wrong");
   a_hard_hold: assert property (
      !capture_phase && external_reset_pin_n |=> $stable(hard_cfg))
      else $error("hard config moved outside reset");
   a_loader_write: assert property (
      loader_window_open && loader_wr_en && external_reset_pin_n |=>
      flow_cfg == (($past(flow_cfg) & ~$past(loader_wr_mask)) |
      ($past(loader_wr_data) & $past(loader_wr_mask))))
      else $error("loader write wrong");
   a_sw_write: assert property (
      config_ready && sw_wr_en && external_reset_pin_n |=>
      flow_cfg == (($past(flow_cfg) & ~$past(sw_wr_mask)) |
      ($past(sw_wr_data) & $past(sw_wr_mask))))
      else $error("software write wrong");
   a_cfg_hold: assert property (
      config_ready && !sw_wr_en && external_reset_pin_n |=>
      $stable(flow_cfg)) else $error("flow config moved unasked");
   a_pause_select: assert property (
      config_ready |=> port2_pause_active == $past(p2_sel) &&
      host_pause_active == $past(host_sel)) else $error("pause wrong");
   a_pause_idle: assert property (
      !config_ready && !$past(config_ready) |->
      port2_pause_active == 2'h0 && host_pause_active == 2'h0)
      else $error("pause active outside run");
   cover property (loader_window_open && loader_wr_en);
   cover property (loader_window_open && loader_done);
   cover property (config_ready && sw_wr_en);
   cover property (config_ready && !external_reset_pin_n);
endmodule
bind strap_config_latch strap_config_latch_monitor mon (.*);
`default_nettype wire

// >>> strap_loader_model.sv
// Eeprom loader model that writes soft strap overrides
`default_nettype none
module strap_loader_model (
   input wire logic core_clk,
   output logic loader_wr_en,
   output strap_config_pkg::flow_cfg_t loader_wr_data,
   output strap_config_pkg::flow_cfg_t loader_wr_mask,
   output logic loader_done
);
   timeunit 1ns;
   timeprecision 1ps;
   import strap_config_pkg::*;
   initial begin
      loader_wr_en = 1'b0;
      loader_done = 1'b0;
      loader_wr_data = 9'h000;
      loader_wr_mask = 9'h000;
   end
   // Held through one rising edge; back to back calls allowed
   task automatic write(flow_cfg_t d, flow_cfg_t m);
      loader_wr_en = 1'b1;
      loader_wr_data = d;
      loader_wr_mask = m;
      @(negedge core_clk);
   endtask
   // Released data is inverted so stale values cannot pass
   task automatic stop();
      loader_wr_en = 1'b0;
      loader_wr_data = ~loader_wr_data;
      @(negedge core_clk);
   endtask
   task automatic finish();
      loader_wr_en = 1'b0;
      loader_wr_data = ~loader_wr_data;
      loader_done = 1'b1;
      @(negedge core_clk);
      loader_done = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> strap_config_latch_test.sv
// Self-checking bench for the strap latch
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; \
   if ((got) !== (exp)) begin fails++; \
   $display("Error %s expected %h seen %h", what, exp, got); end end
module strap_config_latch_test;
   timeunit 1ns;
   timeprecision 1ps;
   import strap_config_pkg::*;
   logic core_clk, rst, external_reset_pin_n, loader_wr_en, loader_done;
   logic sw_wr_en, loader_window_open, config_ready;
   soft_strap_t soft_straps;
   hard_strap_t hard_straps;
   flow_cfg_t loader_wr_data, loader_wr_mask, sw_wr_data, sw_wr_mask;
   flow_cfg_t flow_cfg;
   pause_pair_t port2_autoneg_pause, host_virtual_an_pause;
   pause_pair_t port2_pause_active, host_pause_active;
   hard_cfg_t hard_cfg;
   int fails, checks_done, cycles;
   strap_config_latch dut (.*);
   strap_loader_model partner (.*);
   always #4 core_clk = ~core_clk;
   function automatic flow_cfg_t exp_flow(soft_strap_t s);
      return {s[5], s[4], s[4], ~s[5], s[3], s[2], s[2], s[1], s[0]};
   endfunction
   function automatic logic [17:0] exp_hard(hard_strap_t h);
      return {h[3], h[2:1], 4'h0, h[0], 5'(h[0]) + 5'h01,
         5'(h[0]) + 5'h02};
   endfunction
   task automatic tick(int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic restart(soft_strap_t s, hard_strap_t h, bit by_pin);
      soft_straps = s;
      hard_straps = h;
      if (by_pin) begin
         external_reset_pin_n = 1'b0;
         tick(2);
         external_reset_pin_n = 1'b1;
      end else begin
         rst = 1'b1;
         tick(10);
         `CHK("reset flow", 9'h0fc, flow_cfg)
         `CHK("reset hard", 18'h00022, hard_cfg)
         rst = 1'b0;
      end
      tick(1);
   endtask
   task automatic sw_write(flow_cfg_t d, flow_cfg_t m);
      sw_wr_en = 1'b1;
      sw_wr_data = d;
      sw_wr_mask = m;
      tick(1);
      sw_wr_en = 1'b0;
      sw_wr_data = ~d;
   endtask
   // Capture by either reset, then pins move and must not matter
   task automatic t_capture(int i);
      soft_strap_t s;
      hard_strap_t h;
      s = 6'(i * 6'h15);
      h = {i[0], 2'(i), ~i[0]};
      restart(s, h, i[0]);
      `CHK("flow", exp_flow(s), flow_cfg)
      `CHK("hard", exp_hard(h), hard_cfg)
      `CHK("load phase", 1'b1, loader_window_open)
      soft_straps = ~s;
      hard_straps = ~h;
      partner.finish();
      tick(2);
      `CHK("ready", 1'b1, config_ready)
      `CHK("held flow", exp_flow(s), flow_cfg)
      `CHK("held hard", exp_hard(h), hard_cfg)
   endtask
   task automatic t_flow();
      restart(6'h00, 4'h0, 1'b1);
      sw_write(9'h1ff, 9'h1ff);
      `CHK("early sw", 9'h020, flow_cfg)
      partner.write(9'h1ff, 9'h003);
      `CHK("loader 1", 9'h023, flow_cfg)
      partner.write(9'h000, 9'h020);
      `CHK("loader 2", 9'h003, flow_cfg)
      partner.finish();
      `CHK("loader hard", 18'h00022, hard_cfg)
      partner.write(9'h1ff, 9'h1ff);
      partner.stop();
      `CHK("late loader", 9'h003, flow_cfg)
      port2_autoneg_pause = 2'b01;
      host_virtual_an_pause = 2'b10;
      sw_write(9'h1c0, 9'h1e0);
      tick(1);
      `CHK("sw flow", 9'h1c3, flow_cfg)
      `CHK("p2 manual", 2'b11, port2_pause_active)
      `CHK("host manual", 2'b00, host_pause_active)
      sw_write(9'h000, 9'h102);
      tick(1);
      `CHK("sw flow 2", 9'h0c1, flow_cfg)
      `CHK("p2 auto", 2'b01, port2_pause_active)
      `CHK("host auto", 2'b10, host_pause_active)
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Whole run is under sixty cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         print_verdict();
      end
   end
   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      external_reset_pin_n = 1'b1;
      sw_wr_en = 1'b0;
      sw_wr_data = 9'h000;
      sw_wr_mask = 9'h000;
      soft_straps = 6'h00;
      hard_straps = 4'h0;
      port2_autoneg_pause = 2'b00;
      host_virtual_an_pause = 2'b00;
      for (int i = 0; i < 4; i++) begin
         t_capture(i);
      end
      t_flow();
      print_verdict();
   end
endmodule
`default_nettype wire
